/* File: hw/cdr_pkg.sv */
// Shared constants, types and lane arithmetic for the configurable RAM block.
// Assumes a single 200 MHz clock domain and a 32-bit APB register port.
package cdr_pkg;
   // Storage geometry
   localparam int ROWS = 128;
   localparam int ROW_W = 36;
   localparam int ROW_AW = 7;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 36;
   localparam int BE_W = 4;
   localparam int BYTE_W = 9;
   localparam int CAP_BITS = 4608;
   localparam int MAX_OUT_W = 36;
   localparam int PADDR_W = 8;
   // Register offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] WIDTH_OFS = 8'h04;
   localparam logic [7:0] SHCFG_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;
   localparam logic [7:0] INITADR_OFS = 8'h10;
   localparam logic [7:0] INITDAT_OFS = 8'h14;
   // Field positions
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_AOREG_BIT = 4;
   localparam int CTRL_BOREG_BIT = 5;
   localparam int CTRL_BASYNC_BIT = 6;
   localparam int CTRL_W = 7;
   localparam int WIDTH_B_LSB = 4;
   localparam int SHCFG_LEN_W = 13;
   localparam int SHCFG_TAPS_LSB = 16;
   localparam int SHCFG_TAPS_W = 6;
   localparam int STAT_ERR_BIT = 0;
   localparam int STAT_COLL_BIT = 1;
   localparam int STAT_ROMWR_BIT = 2;
   localparam int STAT_ACT_BIT = 3;
   localparam int INIT_LANE_LSB = 7;
   // Reset values
   localparam logic [6:0] CTRL_RST = 7'h00;
   localparam logic [7:0] WIDTH_RST = 8'h00;
   localparam logic [12:0] SHLEN_RST = 13'h0001;
   localparam logic [5:0] SHTAPS_RST = 6'h01;

   typedef enum logic [2:0] {CDR_TDP, CDR_SDP, CDR_SP, CDR_DSP, CDR_ROM, CDR_SHIFT} cdr_mode_t;
   typedef enum logic [3:0] {CDR_X1, CDR_X2, CDR_X4, CDR_X8, CDR_X16, CDR_X32,
                             CDR_X9, CDR_X18, CDR_X36} cdr_width_t;

   // Log2 of units held in one row
   function automatic logic [2:0] cdr_lane_bits(input logic [3:0] w);
      unique case (w)
         CDR_X1: return 3'h5;
         CDR_X2: return 3'h4;
         CDR_X4: return 3'h3;
         CDR_X8, CDR_X9: return 3'h2;
         CDR_X16, CDR_X18: return 3'h1;
         default: return 3'h0;
      endcase
   endfunction

   // Port width in bits, zero for an illegal code
   function automatic logic [5:0] cdr_wbits(input logic [3:0] w);
      unique case (w)
         CDR_X1: return 6'h01;
         CDR_X2: return 6'h02;
         CDR_X4: return 6'h04;
         CDR_X8: return 6'h08;
         CDR_X16: return 6'h10;
         CDR_X32: return 6'h20;
         CDR_X9: return 6'h09;
         CDR_X18: return 6'h12;
         CDR_X36: return 6'h24;
         default: return 6'h00;
      endcase
   endfunction

   function automatic logic cdr_is_par(input logic [3:0] w);
      return (w == CDR_X9) || (w == CDR_X18) || (w == CDR_X36);
   endfunction

   function automatic logic [35:0] cdr_wmask(input logic [3:0] w);
      return (36'h1 << cdr_wbits(w)) - 36'h1;
   endfunction

   // Row and lane of a unit address
   function automatic logic [6:0] cdr_row(input logic [11:0] a, input logic [3:0] w);
      logic [11:0] t;
      t = a >> cdr_lane_bits(w);
      return t[6:0];
   endfunction

   function automatic logic [4:0] cdr_lane(input logic [11:0] a, input logic [3:0] w);
      logic [11:0] t;
      t = a & ((12'h1 << cdr_lane_bits(w)) - 12'h1);
      return t[4:0];
   endfunction

   // Drop or insert the per-byte extra bit
   function automatic logic [35:0] cdr_strip(input logic [35:0] r);
      return {4'h0, r[34:27], r[25:18], r[16:9], r[7:0]};
   endfunction

   function automatic logic [35:0] cdr_ins(input logic [35:0] v);
      return {1'b0, v[31:24], 1'b0, v[23:16], 1'b0, v[15:8], 1'b0, v[7:0]};
   endfunction

   function automatic logic [35:0] cdr_rd(input logic [35:0] r, input logic [4:0] ln, input logic [3:0] w);
      logic [35:0] src;
      src = cdr_is_par(w) ? r : cdr_strip(r);
      return (src >> (int'(ln) * int'(cdr_wbits(w)))) & cdr_wmask(w);
   endfunction

   function automatic logic [35:0] cdr_wr_mask(input logic [4:0] ln, input logic [3:0] w, input logic [3:0] be);
      logic [35:0] bm;
      logic [35:0] m;
      bm = cdr_is_par(w) ? {{9{be[3]}}, {9{be[2]}}, {9{be[1]}}, {9{be[0]}}}
                         : {4'h0, {8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      if (!((w == CDR_X16) || (w == CDR_X32) || (w == CDR_X18) || (w == CDR_X36)))
         bm = {36{1'b1}};
      m = (cdr_wmask(w) & bm) << (int'(ln) * int'(cdr_wbits(w)));
      return cdr_is_par(w) ? m : cdr_ins(m);
   endfunction

   function automatic logic [35:0] cdr_wr_data(input logic [35:0] d, input logic [4:0] ln, input logic [3:0] w);
      logic [35:0] v;
      v = (d & cdr_wmask(w)) << (int'(ln) * int'(cdr_wbits(w)));
      return cdr_is_par(w) ? v : cdr_ins(v);
   endfunction
endpackage

/* File: hw/cdr_port.sv */
// One user port of the RAM block: input capture, write pulse, output stage.
// Assumes the driving user logic runs on pclk; the array read is done outside.
module cdr_port (
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic clk_en, // Port clock enable
   input wire logic clr, // Port clear of all port registers
   input wire logic in_bypass, // Use live address and read enable
   input wire logic out_reg_en, // Registered read output
   input wire logic [cdr_pkg::ADDR_W-1:0] addr_in, // Address from user logic
   input wire logic [cdr_pkg::DATA_W-1:0] din_in, // Write data from user logic
   input wire logic [cdr_pkg::BE_W-1:0] be_in, // Byte enables from user logic
   input wire logic we_in, // Write request
   input wire logic re_in, // Read request
   input wire logic rd_take, // Array data valid for the output stage
   input wire logic [cdr_pkg::DATA_W-1:0] rd_raw, // Array data at the used address
   output logic [cdr_pkg::ADDR_W-1:0] addr, // Address in use
   output logic [cdr_pkg::DATA_W-1:0] din, // Captured write data
   output logic [cdr_pkg::BE_W-1:0] be, // Captured byte enables
   output logic we, // One-cycle write pulse
   output logic re, // Read enable in use
   output logic [cdr_pkg::DATA_W-1:0] q // Read data to user logic
);
   import cdr_pkg::*;

   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] din_reg;
   logic [BE_W-1:0] be_reg;
   logic we_reg;
   logic re_reg;
   logic [DATA_W-1:0] q_reg;

   // Input capture; strobes last one enabled cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addr_reg <= '0;
         din_reg <= '0;
         be_reg <= '0;
         we_reg <= 1'b0;
         re_reg <= 1'b0;
      end
      else if (clr) // R20
      begin
         addr_reg <= '0;
         din_reg <= '0;
         be_reg <= '0;
         we_reg <= 1'b0;
         re_reg <= 1'b0;
      end
      else
      begin
         we_reg <= clk_en & we_in; // R10
         re_reg <= clk_en & re_in;
         if (clk_en) // R09
         begin
            addr_reg <= addr_in;
            din_reg <= din_in;
            be_reg <= be_in;
         end
      end
   end

   // Output pipeline stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q_reg <= '0;
      else if (clr)
         q_reg <= '0;
      else if (rd_take)
         q_reg <= rd_raw;
   end

   // Selection of captured or live signals
   assign addr = in_bypass ? addr_in : addr_reg; // R12
   assign re = in_bypass ? re_in : re_reg;
   assign din = din_reg;
   assign be = be_reg;
   assign we = we_reg;
   assign q = out_reg_en ? q_reg : rd_raw; // R11
endmodule

/* File: hw/cdr_ram.sv */
// Configurable 4608-bit RAM block with two user ports and an APB register port.
// Assumes user logic and APB master share pclk; the array has no reset.
//
// The register addresses and the APB slave port were left to the implementer.

// Notes on behaviour
// [R01] Shapes 4096x1 to 128x36 over 4608 bits selected per port.
// [R02] True dual-port refuses 32 and 36 bit shapes.
// [R03] True dual-port serves any read/write pair on both ports.
// [R04] Simple dual-port: port A writes only, port B reads only.
// [R05] Single-port serves one access a cycle; user must not request both.
// [R06] Dual single-port mode splits rows in halves, one per port.
// [R07] Ports may use different widths over the same storage.
// [R08] Mixed widths stay within plain or extra-bit width family.
// [R09] All port inputs are captured in registers on the clock.
// [R10] Write strobe is a self-timed one-cycle pulse from the clock.
// [R11] Each read output is registered or taken straight from the array.
// [R12] Simple dual-port read may bypass input and output registers.
// [R13] Contents can be preset before operation starts.
// [R14] One extra stored bit per byte for parity or control.
// [R15] Byte enables mask which byte lanes a write updates.
// [R16] Shift width times spacing times taps must fit the capacity.
// [R17] Shift output width taps times width stays within 36 bits.
// [R18] Shift mode reads old and writes new data each cycle; here only in cycles with a port A write.
// [R19] Byte masking only at 16, 18, 32, 36 bits; other bytes kept.
// [R20] Each port has its own clock enable and clear.
// [R21] Writing port governs write inputs, reading port the read side.
// [R22] Address bits used equal log2 of the selected port depth.
module cdr_ram #(
   parameter int MAX_TAPS = 8 // Tap read paths built for shift mode
) (
   input wire logic pclk, // System clock, 200 MHz
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic [cdr_pkg::PADDR_W-1:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic a_clk_en, // Port A clock enable
   input wire logic a_clr, // Port A clear
   input wire logic [cdr_pkg::ADDR_W-1:0] a_addr, // Port A address
   input wire logic [cdr_pkg::DATA_W-1:0] a_din, // Port A write data
   input wire logic [cdr_pkg::BE_W-1:0] a_be, // Port A byte enables
   input wire logic a_we, // Port A write request
   input wire logic a_re, // Port A read request
   output logic [cdr_pkg::DATA_W-1:0] a_q, // Port A read data
   input wire logic b_clk_en, // Port B clock enable
   input wire logic b_clr, // Port B clear
   input wire logic [cdr_pkg::ADDR_W-1:0] b_addr, // Port B address
   input wire logic [cdr_pkg::DATA_W-1:0] b_din, // Port B write data
   input wire logic [cdr_pkg::BE_W-1:0] b_be, // Port B byte enables
   input wire logic b_we, // Port B write request
   input wire logic b_re, // Port B read request
   output logic [cdr_pkg::DATA_W-1:0] b_q // Port B read data or shift taps
);
   import cdr_pkg::*;

   logic [ROW_W-1:0] mem [ROWS]; // R14
   logic [CTRL_W-1:0] ctrl_reg;
   logic [7:0] width_reg;
   logic [SHCFG_LEN_W-1:0] shlen_reg;
   logic [SHCFG_TAPS_W-1:0] shtaps_reg;
   logic [8:0] init_reg;
   logic coll_reg;
   logic romwr_reg;
   logic [12:0] ptr_reg;
   logic [31:0] prdata_reg;

   // Configuration fields
   logic run;
   cdr_mode_t mode;
   logic [3:0] wa;
   logic [3:0] wb;
   assign run = ctrl_reg[CTRL_RUN_BIT];
   assign mode = cdr_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 3]);
   assign wa = width_reg[3:0]; // R07
   assign wb = width_reg[WIDTH_B_LSB +: 4];

   // Shape legality checks
   logic bad_code;
   logic bad_family;
   logic bad_wide;
   logic [18:0] sh_units;
   logic [24:0] sh_bits;
   logic [11:0] tap_out_w;
   logic [12:0] depth_a;
   logic bad_shift;
   logic cfg_err;
   logic act;
   assign bad_code = (ctrl_reg[CTRL_MODE_LSB +: 3] > 3'(CDR_SHIFT)) || (cdr_wbits(wa) == 6'h00)
                     || (cdr_wbits(wb) == 6'h00); // R01
   assign bad_family = (cdr_is_par(wa) != cdr_is_par(wb))
                       && ((mode == CDR_TDP) || (mode == CDR_SDP) || (mode == CDR_ROM)); // R08
   assign bad_wide = (mode == CDR_TDP) && ((wa == CDR_X32) || (wa == CDR_X36)
                     || (wb == CDR_X32) || (wb == CDR_X36)); // R02
   assign sh_units = 19'(shlen_reg) * 19'(shtaps_reg);
   assign sh_bits = 25'(sh_units) * 25'(cdr_wbits(wa));
   assign tap_out_w = 12'(shtaps_reg) * 12'(cdr_wbits(wa));
   assign depth_a = 13'(ROWS) << cdr_lane_bits(wa);
   assign bad_shift = (mode == CDR_SHIFT) && ((shlen_reg == '0) || (shtaps_reg == '0)
                      || (sh_bits > 25'(CAP_BITS)) || (tap_out_w > 12'(MAX_OUT_W)) // R16 R17
                      || (sh_units > 19'(depth_a)) || (32'(shtaps_reg) > 32'(MAX_TAPS)));
   assign cfg_err = bad_code || bad_family || bad_wide || bad_shift;
   assign act = run && !cfg_err;

   // Port signals in use
   logic [ADDR_W-1:0] pa_addr;
   logic [ADDR_W-1:0] pb_addr;
   logic [DATA_W-1:0] pa_din;
   logic [DATA_W-1:0] pb_din;
   logic [BE_W-1:0] pa_be;
   logic [BE_W-1:0] pb_be;
   logic pa_we;
   logic pb_we;
   logic pa_re;
   logic pb_re;
   logic [DATA_W-1:0] a_raw;
   logic [DATA_W-1:0] b_raw;
   logic b_bypass;
   logic a_take;
   logic b_take;

   // Asynchronous-looking read only in simple dual-port mode
   assign b_bypass = (mode == CDR_SDP) && ctrl_reg[CTRL_BASYNC_BIT]; // R12

   cdr_port u_port_a (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(a_clk_en),
      .clr(a_clr),
      .in_bypass(1'b0),
      .out_reg_en(ctrl_reg[CTRL_AOREG_BIT]),
      .addr_in(a_addr),
      .din_in(a_din),
      .be_in(a_be),
      .we_in(a_we),
      .re_in(a_re),
      .rd_take(a_take),
      .rd_raw(a_raw),
      .addr(pa_addr),
      .din(pa_din),
      .be(pa_be),
      .we(pa_we),
      .re(pa_re),
      .q(a_q)
   );

   cdr_port u_port_b (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(b_clk_en),
      .clr(b_clr),
      .in_bypass(b_bypass),
      .out_reg_en(ctrl_reg[CTRL_BOREG_BIT] && !b_bypass),
      .addr_in(b_addr),
      .din_in(b_din),
      .be_in(b_be),
      .we_in(b_we),
      .re_in(b_re),
      .rd_take(b_take),
      .rd_raw(b_raw),
      .addr(pb_addr),
      .din(pb_din),
      .be(pb_be),
      .we(pb_we),
      .re(pb_re),
      .q(b_q)
   );

   // Row and lane per port; dual single-port pins the top row bit
   logic dsp;
   logic [ROW_AW-1:0] a_row0;
   logic [ROW_AW-1:0] b_row0;
   logic [ROW_AW-1:0] a_row;
   logic [ROW_AW-1:0] b_row;
   logic [4:0] a_lane;
   logic [4:0] b_lane;
   assign dsp = (mode == CDR_DSP);
   assign a_row0 = cdr_row(pa_addr, wa); // R22
   assign b_row0 = cdr_row(pb_addr, wb);
   assign a_row = dsp ? {1'b0, a_row0[ROW_AW-2:0]} : a_row0; // R06
   assign b_row = dsp ? {1'b1, b_row0[ROW_AW-2:0]} : b_row0;
   assign a_lane = cdr_lane(pa_addr, wa);
   assign b_lane = cdr_lane(pb_addr, wb);

   // Write decisions per mode
   logic single;
   logic a_wr;
   logic b_wr;
   logic sh_adv;
   logic coll_set;
   logic romwr_set;
   assign single = (mode == CDR_SP) || dsp;
   assign a_wr = act && pa_we && ((mode == CDR_TDP) || (mode == CDR_SDP) || single); // R03 R04 R21
   assign b_wr = act && pb_we && ((mode == CDR_TDP) || dsp);
   assign sh_adv = act && (mode == CDR_SHIFT) && pa_we; // R18
   assign coll_set = act && ((single && pa_we && pa_re) || (dsp && pb_we && pb_re)); // R05
   assign romwr_set = act && (mode == CDR_ROM) && (pa_we || pb_we);

   // Read acceptance; a write wins a single-port collision
   assign a_take = act && pa_re && (mode != CDR_SDP) && (mode != CDR_SHIFT) && !(single && pa_we); // R05
   assign b_take = act && ((pb_re && (mode != CDR_SP) && !(dsp && pb_we)) || sh_adv); // R04

   // Merged row values; B sees A's update on a shared row
   logic [ROW_W-1:0] a_m;
   logic [ROW_W-1:0] b_m;
   logic [ROW_W-1:0] a_new;
   logic [ROW_W-1:0] b_base;
   logic [ROW_W-1:0] b_new;
   assign a_m = cdr_wr_mask(a_lane, wa, pa_be); // R15 R19
   assign b_m = cdr_wr_mask(b_lane, wb, pb_be);
   assign a_new = (mem[a_row] & ~a_m) | (cdr_wr_data(pa_din, a_lane, wa) & a_m);
   assign b_base = (a_wr && (a_row == b_row)) ? a_new : mem[b_row];
   assign b_new = (b_base & ~b_m) | (cdr_wr_data(pb_din, b_lane, wb) & b_m);

   // Shift write slot at the circular pointer
   logic [ROW_AW-1:0] s_row;
   logic [4:0] s_lane;
   logic [ROW_W-1:0] s_m;
   logic [ROW_W-1:0] s_new;
   assign s_row = cdr_row(ptr_reg[ADDR_W-1:0], wa);
   assign s_lane = cdr_lane(ptr_reg[ADDR_W-1:0], wa);
   assign s_m = cdr_wr_mask(s_lane, wa, {BE_W{1'b1}});
   assign s_new = (mem[s_row] & ~s_m) | (cdr_wr_data(pa_din, s_lane, wa) & s_m);

   // Tap k reads the unit written (k+1)*spacing shift writes ago
   logic [DATA_W-1:0] taps;
   always_comb
   begin
      logic [18:0] sub;
      logic [18:0] t;
      logic [DATA_W-1:0] v;
      sub = '0;
      t = '0;
      v = '0;
      taps = '0;
      for (int k = 0; k < MAX_TAPS; k++)
      begin
         sub = 19'(k + 1) * 19'(shlen_reg);
         t = 19'(ptr_reg) + sh_units - sub;
         if (t >= sh_units)
            t = t - sh_units;
         v = cdr_rd(mem[cdr_row(t[ADDR_W-1:0], wa)], cdr_lane(t[ADDR_W-1:0], wa), wa);
         if (19'(k) < 19'(shtaps_reg))
            taps = taps | (v << (k * int'(cdr_wbits(wa)))); // R18
      end
   end

   // Array data to the output stages
   assign a_raw = cdr_rd(mem[a_row], a_lane, wa);
   assign b_raw = (mode == CDR_SHIFT) ? taps : cdr_rd(mem[b_row], b_lane, wb);

   // APB decode
   logic sel_ctrl;
   logic sel_width;
   logic sel_shcfg;
   logic sel_status;
   logic sel_iadr;
   logic sel_idat;
   logic hit;
   logic apb_wr;
   logic init_wr;
   logic [ROW_AW-1:0] init_row;
   logic [1:0] init_lane;
   logic [BYTE_W-1:0] init_byte;
   logic [31:0] rd_mux;
   assign sel_ctrl = (paddr == CTRL_OFS);
   assign sel_width = (paddr == WIDTH_OFS);
   assign sel_shcfg = (paddr == SHCFG_OFS);
   assign sel_status = (paddr == STATUS_OFS);
   assign sel_iadr = (paddr == INITADR_OFS);
   assign sel_idat = (paddr == INITDAT_OFS);
   assign hit = sel_ctrl || sel_width || sel_shcfg || sel_status || sel_iadr || sel_idat;
   assign apb_wr = psel && penable && pwrite && hit;
   assign init_wr = apb_wr && sel_idat && !run; // R13
   assign init_row = init_reg[ROW_AW-1:0];
   assign init_lane = init_reg[INIT_LANE_LSB +: 2];
   assign init_byte = mem[init_row][BYTE_W * int'(init_lane) +: BYTE_W];
   assign rd_mux = sel_ctrl ? 32'(ctrl_reg)
                 : sel_width ? 32'(width_reg)
                 : sel_shcfg ? ((32'(shtaps_reg) << SHCFG_TAPS_LSB) | 32'(shlen_reg))
                 : sel_status ? 32'({act, romwr_reg, coll_reg, cfg_err})
                 : sel_iadr ? 32'(init_reg)
                 : sel_idat ? 32'(init_byte)
                 : 32'h0000_0000;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = prdata_reg;

   // Register writes, read capture in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= CTRL_RST;
         width_reg <= WIDTH_RST;
         shlen_reg <= SHLEN_RST;
         shtaps_reg <= SHTAPS_RST;
         init_reg <= '0;
         prdata_reg <= '0;
      end
      else
      begin
         if (psel && !penable)
            prdata_reg <= rd_mux;
         if (apb_wr && sel_ctrl)
            ctrl_reg <= pwdata[CTRL_W-1:0];
         if (apb_wr && sel_width)
            width_reg <= pwdata[7:0];
         if (apb_wr && sel_shcfg)
         begin
            shlen_reg <= pwdata[SHCFG_LEN_W-1:0];
            shtaps_reg <= pwdata[SHCFG_TAPS_LSB +: SHCFG_TAPS_W];
         end
         if (apb_wr && sel_iadr)
            init_reg <= pwdata[8:0];
         else if (init_wr)
            init_reg <= init_reg + 9'h001;
      end
   end

   // Sticky flags; a new event beats the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         coll_reg <= 1'b0;
         romwr_reg <= 1'b0;
      end
      else
      begin
         coll_reg <= coll_set || (coll_reg && !(apb_wr && sel_status && pwdata[STAT_COLL_BIT]));
         romwr_reg <= romwr_set || (romwr_reg && !(apb_wr && sel_status && pwdata[STAT_ROMWR_BIT]));
      end
   end

   // Shift pointer, wraps at spacing times taps units
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ptr_reg <= '0;
      else if (mode != CDR_SHIFT || !act)
         ptr_reg <= '0;
      else if (sh_adv)
         ptr_reg <= (19'(ptr_reg) + 19'h1 >= sh_units) ? 13'h0000 : ptr_reg + 13'h0001; // R18
   end

   // Storage array writes
   always_ff @(posedge pclk)
   begin
      if (init_wr)
         mem[init_row][BYTE_W * int'(init_lane) +: BYTE_W] <= pwdata[BYTE_W-1:0]; // R13
      if (a_wr)
         mem[a_row] <= a_new; // R15
      if (b_wr)
         mem[b_row] <= b_new; // R03
      if (sh_adv)
         mem[s_row] <= s_new;
   end
endmodule

/* File: bench/cdr_ram_asserts.sv */
// Checker for the RAM block register port answers and read-back.
// Assumes it is bound to cdr_ram and sees only its ports.
module cdr_ram_asserts #(
   parameter int MAX_TAPS = 8 // Same as the design
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic [cdr_pkg::PADDR_W-1:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr // APB error
);
   timeunit 1ns;
   timeprecision 1ps;
   import cdr_pkg::*;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Write access and read setup to one place
   sequence s_wr(ofs);
      psel && penable && pwrite && paddr == ofs;
   endsequence
   sequence s_rd(ofs);
      psel && !penable && !pwrite && paddr == ofs;
   endsequence
   a_ready_high: assert property (pready) else $error("pready low");
   a_err_access: assert property (pslverr |-> psel && penable) else $error("stray error");
   a_err_unmapped: assert property (psel && penable && paddr > 8'h14 |-> pslverr) else $error("no error");
   a_ok_mapped: assert property (psel && penable && paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}
      |-> !pslverr) else $error("false error");
   a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable)) else $error("prdata moved");
   a_rdata_unmap: assert property (psel && !penable && paddr > 8'h14 |=> prdata == 32'h0)
      else $error("unmapped data");
   a_ctrl_readback: assert property (s_wr(CTRL_OFS) ##2 s_rd(CTRL_OFS) |=> prdata[6:0] == $past(pwdata[6:0], 3))
      else $error("control lost");
   a_width_readback: assert property (s_wr(WIDTH_OFS) ##2 s_rd(WIDTH_OFS) |=> prdata[7:0] == $past(pwdata[7:0], 3))
      else $error("width lost");
endmodule
bind cdr_ram cdr_ram_asserts #(.MAX_TAPS(MAX_TAPS)) cdr_ram_asserts_i (.pclk, .presetn, .paddr, .psel, .penable,
   .pwrite, .pwdata, .prdata, .pready, .pslverr);

/* File: bench/cdr_user.sv */
// User logic model: writes on port A, reads on port B.
// Assumes pclk domain; the bench tells it whether B output is registered.
module cdr_user (
   input wire logic pclk, // Clock
   input wire logic b_oreg, // B output register in use
   output logic a_clk_en, // A enable
   output logic [cdr_pkg::ADDR_W-1:0] a_addr, // A address
   output logic [cdr_pkg::DATA_W-1:0] a_din, // A data
   output logic [cdr_pkg::BE_W-1:0] a_be, // A byte enables
   output logic a_we, // A write
   output logic b_clk_en, // B enable
   output logic [cdr_pkg::ADDR_W-1:0] b_addr, // B address
   output logic [cdr_pkg::DATA_W-1:0] b_din, // B data, unused lines
   output logic b_re, // B read
   output logic b_vld // B data due at this edge
);
   timeunit 1ns;
   timeprecision 1ps;
   import cdr_pkg::*;
   logic [1:0] pipe_reg;
   // Idle values
   initial {a_clk_en, b_clk_en, a_addr, a_din, a_be, a_we, b_addr, b_re} = {2'h3, 66'h0};
   assign b_din = ~a_din;
   // Data due one edge after capture, or two when registered
   always @(posedge pclk) pipe_reg <= {pipe_reg[0], b_re};
   assign b_vld = b_oreg ? pipe_reg[1] : pipe_reg[0];
   // One write; released lines turn inverted
   task automatic wr(input logic [11:0] ad, input logic [35:0] d, input logic [3:0] be);
      @(posedge pclk);
      {a_addr, a_din, a_be, a_we} <= {ad, d, be, 1'b1};
      @(posedge pclk);
      {a_addr, a_din, a_we} <= {~ad, ~d, 1'b0};
   endtask
   // One read, then wait for the result
   task automatic rd(input logic [11:0] ad);
      @(posedge pclk);
      {a_addr, b_addr, b_re} <= {ad, ad, 1'b1};
      @(posedge pclk);
      {b_addr, b_re} <= {~ad, 1'b0};
      repeat (3) @(posedge pclk);
   endtask
endmodule

/* File: bench/cdr_ram_tb_top.sv */
// Self-checking bench: APB master, user model, queue scoreboard.
// Assumes cdr_pkg, cdr_user and the bound checker are compiled first.
module cdr_ram_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cdr_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic b_oreg = 1'b0;
   logic a_chk = 1'b0;
   logic [35:0] e;
   logic [35:0] exp_q[$];
   int n_fail = 0;
   int checks = 0;
   wire logic pready, pslverr, b_vld, a_clk_en, a_we, b_clk_en, b_re;
   wire logic [31:0] prdata;
   wire logic [11:0] a_addr, b_addr;
   wire logic [35:0] a_din, b_din, a_q, b_q;
   wire logic [3:0] a_be;
`define CDR_CHK(got) begin checks++; e = exp_q.pop_front(); if ((got) !== e) begin n_fail++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e); end end
   always #2.5 pclk = ~pclk;
   cdr_ram cdr_ram_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .a_clk_en, .a_clr(1'b0), .a_addr, .a_din, .a_be, .a_we, .a_re(1'b0), .a_q, .b_clk_en, .b_clr(1'b0),
      .b_addr, .b_din, .b_be(4'h0), .b_we(1'b0), .b_re, .b_q);
   cdr_user cdr_user_i (.pclk, .b_oreg, .a_clk_en, .a_addr, .a_din, .a_be, .a_we, .b_clk_en, .b_addr, .b_din,
      .b_re, .b_vld);
   // Scoreboard: oldest note against each result
   always @(posedge pclk)
   begin
      if (psel && penable && pready && !pwrite)
         `CDR_CHK({4'h0, prdata})
      if (b_vld === 1'b1)
         `CDR_CHK(b_q)
      if (b_vld === 1'b1 && a_chk)
         `CDR_CHK(a_q)
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {psel, penable} <= 2'b00;
   endtask
   task automatic rdr(input logic [7:0] a, input logic [35:0] x);
      exp_q.push_back(x);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic urd(input logic [11:0] a, input logic [35:0] x);
      exp_q.push_back(x);
      cdr_user_i.rd(a);
   endtask
   task automatic report_and_stop;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      repeat (5000) @(posedge pclk);
      n_fail++;
      report_and_stop;
   end
   // Tests
   initial
   begin
      logic [15:0] d;
      logic [11:0] ad;
      void'($urandom(32'h6e6c));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdr(CTRL_OFS, 36'h0);
      rdr(WIDTH_OFS, 36'h0);
      rdr(SHCFG_OFS, 36'h0001_0001);
      rdr(STATUS_OFS, 36'h0);
      rdr(8'h18, 36'h0);
      $display("test reset values done");
      apb(1'b1, INITADR_OFS, 32'h5);
      apb(1'b1, INITDAT_OFS, 32'h1AB);
      apb(1'b1, WIDTH_OFS, 32'h67);
      apb(1'b1, CTRL_OFS, 32'h21);
      rdr(CTRL_OFS, 36'h21);
      b_oreg <= 1'b1;
      urd(12'h014, 36'h1AB);
      $display("test preset done");
      apb(1'b1, WIDTH_OFS, 32'h34);
      rdr(WIDTH_OFS, 36'h34);
      cdr_user_i.wr(12'h3, 36'hBEEF, 4'h3);
      cdr_user_i.wr(12'h3, 36'h1234, 4'h2);
      urd(12'h6, 36'hEF);
      urd(12'h7, 36'h12);
      $display("test byte enables done");
      apb(1'b1, WIDTH_OFS, 32'h44);
      a_chk <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         d = 16'($urandom);
         ad = {4'h0, 8'($urandom)};
         b_oreg <= i[0];
         apb(1'b1, CTRL_OFS, {26'h0, i[0], 5'h01});
         cdr_user_i.wr(ad, {20'h0, d}, 4'hF);
         exp_q.push_back({20'h0, d});
         urd(ad, {20'h0, d});
      end
      $display("test random words done");
      report_and_stop;
   end
endmodule
